//--- include/imsb_defs.vh
// register offsets, field positions, reset values and timing for the i2c master sequencer
// assumes a 20 MHz reference clock standing in for the quarter-phase clock of the instruction cycle
`ifndef IMSB_DEFS_VH
`define IMSB_DEFS_VH

// register byte offsets
`define IMSB_OFS_CTRL2      8'h00
`define IMSB_OFS_STATUS     8'h04
`define IMSB_OFS_ADDR_BAUD  8'h08
`define IMSB_OFS_BUFFER     8'h0C
`define IMSB_OFS_FLAGS      8'h10

// control_reg_two fields
`define IMSB_C2_START       0
`define IMSB_C2_RESTART     1
`define IMSB_C2_STOP        2
`define IMSB_C2_RECEIVE     3
`define IMSB_C2_ACKSEQ      4
`define IMSB_C2_ACKDATA     5
`define IMSB_C2_ACKSTAT     6
`define IMSB_C2_CMD_MASK    8'h1F

// port_status_reg fields
`define IMSB_ST_FULL        0
`define IMSB_ST_START_SEEN  3
`define IMSB_ST_STOP_SEEN   4

// flags register fields, write one to clear
`define IMSB_FL_PORT_IRQ    0
`define IMSB_FL_BUS_COLL    1
`define IMSB_FL_WR_COLL     2
`define IMSB_FL_RX_OVF      3

// reset values
`define IMSB_RST_BYTE       8'h00
`define IMSB_RST_BAUD       7'h00

// bit rate counter ticks on two of four quarter phases
`define IMSB_PHASE_W        2
`define IMSB_BRG_W          7

// bit transfer counts: eight data bits then the acknowledge slot
`define IMSB_LAST_DATA_BIT  4'h7
`define IMSB_ACK_BIT        4'h8

`endif

//--- src/imsb_core.v
// i2c master sequencer: bit rate counter, clock arbitration, start, repeated start,
// byte transfer, acknowledge and stop sequences with collision detection
// assumes open-drain sda/scl resolved outside; lines arrive asynchronously
//
// Implementation choices: the plain strobed port and the placing of the registers.
`include "imsb_defs.vh"
`default_nettype none

// Operation
// - master makes every scl pulse, start and stop; restart keeps the bus
// - transmit: first byte is address plus direction zero, bytes then ack
// - receive: first byte is address plus direction one, master acks each byte
// - after eight bits, sample slave ack into ack status bit
// - set port interrupt flag at end of ninth clock of sent byte
// - start request is bit 0, stop request bit 2; irq after stop completes
// - reload is low seven bits of address/baud; buffer write starts counter
// - counter decrements twice per instruction cycle, halts at zero until reload
// - finished operation stops the bit clock and leaves scl as driven
// - one scl period spans two counter rollovers
// - on scl release, wait for scl high, then reload from bits 6:0
// - start with both lines high: load, at timeout pull sda low, start seen
// - after sda low reload, at timeout clear start bit and hold sda low
// - lines low at start or scl low early: bus collision, abort, idle
// - buffer write during a sequence is dropped and sets write collision
// - low five control bits are write-blocked until any running start, restart, stop, transfer or ack completes
// - restart from idle: pull scl low, once low load bits 5:0, release sda
// - then release scl, reload on high, pull sda low a period, clear restart
// - start seen set from lines at once; irq only after counter timeout
// - restart request while another event runs has no effect
// - restart collision: sda low as scl rises, or scl falls before sda pulled
// - stop: sda low, period, scl release, period, sda release, period, irq
module imsb_core (
    input  wire       I_REF_CLK,
    input  wire       I_RST_N,
    input  wire [7:0] I_ADDR,
    input  wire [7:0] I_WDATA,
    input  wire       I_WR,
    input  wire       I_RD,
    output reg  [7:0] O_RDATA,
    input  wire       I_SDA,
    output reg        O_SDA,
    output reg        O_SDA_OE_N,
    input  wire       I_SCL,
    output reg        O_SCL,
    output reg        O_SCL_OE_N,
    output reg        O_PORT_IRQ_FLAG,
    output reg        O_BUS_COLLISION_FLAG
);

    localparam S_IDLE      = 5'h00;
    localparam S_ST_WAIT   = 5'h01;
    localparam S_ST_HOLD   = 5'h02;
    localparam S_RS_LOW    = 5'h03;
    localparam S_RS_SDAHI  = 5'h04;
    localparam S_RS_WAITHI = 5'h05;
    localparam S_RS_HIGH   = 5'h06;
    localparam S_RS_SDALO  = 5'h07;
    localparam S_BIT_LOW   = 5'h08;
    localparam S_BIT_WAIT  = 5'h09;
    localparam S_BIT_HIGH  = 5'h0A;
    localparam S_AK_LOW    = 5'h0B;
    localparam S_AK_WAIT   = 5'h0C;
    localparam S_AK_HIGH   = 5'h0D;
    localparam S_SP_WAITLO = 5'h0E;
    localparam S_SP_LOW    = 5'h0F;
    localparam S_SP_WAITHI = 5'h10;
    localparam S_SP_HIGH   = 5'h11;
    localparam S_SP_WAITP  = 5'h12;
    localparam S_SP_END    = 5'h13;

    // line synchronisers
    reg        sda_m_r;
    reg        sda_s_r;
    reg        sda_d_r;
    reg        scl_m_r;
    reg        scl_s_r;

    reg  [4:0] state_r;
    reg  [4:0] state_nxt;
    reg  [`IMSB_PHASE_W-1:0] phase_r;
    reg  [`IMSB_BRG_W-1:0]   brg_r;
    reg        brg_busy_r;
    reg        brg_load;
    reg  [`IMSB_BRG_W-1:0]   brg_val;

    reg  [4:0] cmd_r;
    reg  [4:0] cmd_nxt;
    reg        ackdt_r;
    reg        ackstat_r;
    reg        ackstat_nxt;
    reg  [6:0] baud_r;
    reg  [7:0] buf_r;
    reg  [7:0] buf_nxt;
    reg        full_r;
    reg        full_nxt;
    reg  [7:0] shift_r;
    reg  [7:0] shift_nxt;
    reg  [3:0] bit_cnt_r;
    reg  [3:0] bit_cnt_nxt;
    reg        rx_mode_r;
    reg        rx_mode_nxt;
    reg        sda_oen_nxt;
    reg        scl_oen_nxt;
    reg        start_seen_r;
    reg        stop_seen_r;
    reg        write_collision_flag_r;
    reg        ovf_r;
    reg        set_irq;
    reg        set_bcl;
    reg        set_write_collision_flag;
    reg        set_ovf;
    reg        collide;

    wire       tick     = phase_r[0];
    wire       timeout  = brg_busy_r & tick & (brg_r == `IMSB_RST_BAUD);
    wire       wr_c2    = I_WR & (I_ADDR == `IMSB_OFS_CTRL2);
    wire       wr_baud  = I_WR & (I_ADDR == `IMSB_OFS_ADDR_BAUD);
    wire       wr_buf   = I_WR & (I_ADDR == `IMSB_OFS_BUFFER);
    wire       wr_flags = I_WR & (I_ADDR == `IMSB_OFS_FLAGS);
    wire       rd_buf   = I_RD & (I_ADDR == `IMSB_OFS_BUFFER);
    wire       idle     = (state_r == S_IDLE) & (cmd_r == 5'h00);
    wire [6:0] rel_full = baud_r;
    wire [6:0] rel_half = {1'b0, baud_r[5:0]};

    // sample the open-drain lines
    always @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_d_r <= 1'b1;
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
        end else begin
            sda_m_r <= I_SDA;
            sda_s_r <= sda_m_r;
            sda_d_r <= sda_s_r;
            scl_m_r <= I_SCL;
            scl_s_r <= scl_m_r;
        end
    end

    // bit rate counter ticking on quarter phases 1 and 3
    always @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            phase_r    <= 2'h0;
            brg_r      <= `IMSB_RST_BAUD;
            brg_busy_r <= 1'b0;
        end else begin
            phase_r <= phase_r + 2'h1;
            if (brg_load) begin
                brg_r      <= brg_val;
                brg_busy_r <= 1'b1;
            end else if (tick & brg_busy_r) begin
                if (brg_r == `IMSB_RST_BAUD)
                    brg_busy_r <= 1'b0;
                else
                    brg_r <= brg_r - 7'h01;
            end
        end
    end

    // sequencer
    always @* begin
        state_nxt   = state_r;
        cmd_nxt     = cmd_r;
        ackstat_nxt = ackstat_r;
        buf_nxt     = buf_r;
        full_nxt    = full_r;
        shift_nxt   = shift_r;
        bit_cnt_nxt = bit_cnt_r;
        rx_mode_nxt = rx_mode_r;
        sda_oen_nxt = O_SDA_OE_N;
        scl_oen_nxt = O_SCL_OE_N;
        brg_load    = 1'b0;
        brg_val     = rel_full;
        set_irq     = 1'b0;
        set_bcl     = 1'b0;
        set_write_collision_flag    = 1'b0;
        set_ovf     = 1'b0;
        collide     = 1'b0;
        if (rd_buf)
            full_nxt = 1'b0;
        if (wr_c2 && state_r == S_IDLE && cmd_r == 5'h00)
            cmd_nxt = I_WDATA[4:0];
        if (wr_buf && !idle)
            set_write_collision_flag = 1'b1;
        case (state_r)
            S_IDLE: begin
                if (wr_buf && idle) begin
                    buf_nxt     = I_WDATA;
                    shift_nxt   = I_WDATA;
                    full_nxt    = 1'b1;
                    bit_cnt_nxt = 4'h0;
                    rx_mode_nxt = 1'b0;
                    scl_oen_nxt = 1'b0;
                    brg_load    = 1'b1;
                    state_nxt   = S_BIT_LOW;
                end else if (cmd_r[`IMSB_C2_START]) begin
                    if (sda_s_r && scl_s_r) begin
                        brg_load  = 1'b1;
                        state_nxt = S_ST_WAIT;
                    end else if (!sda_s_r && !scl_s_r) begin
                        collide = 1'b1;
                    end
                end else if (cmd_r[`IMSB_C2_RESTART]) begin
                    scl_oen_nxt = 1'b0;
                    state_nxt   = S_RS_LOW;
                end else if (cmd_r[`IMSB_C2_STOP]) begin
                    sda_oen_nxt = 1'b0;
                    state_nxt   = S_SP_WAITLO;
                end else if (cmd_r[`IMSB_C2_RECEIVE]) begin
                    bit_cnt_nxt = 4'h0;
                    rx_mode_nxt = 1'b1;
                    scl_oen_nxt = 1'b0;
                    sda_oen_nxt = 1'b1;
                    brg_load    = 1'b1;
                    state_nxt   = S_BIT_LOW;
                end else if (cmd_r[`IMSB_C2_ACKSEQ]) begin
                    scl_oen_nxt = 1'b0;
                    sda_oen_nxt = ackdt_r;
                    brg_load    = 1'b1;
                    state_nxt   = S_AK_LOW;
                end
            end
            S_ST_WAIT: begin
                if (!scl_s_r) begin
                    collide = 1'b1;
                end else if (timeout) begin
                    if (sda_s_r) begin
                        sda_oen_nxt = 1'b0;
                        brg_load    = 1'b1;
                        state_nxt   = S_ST_HOLD;
                    end else begin
                        collide = 1'b1;
                    end
                end
            end
            S_ST_HOLD: begin
                if (timeout) begin
                    cmd_nxt[`IMSB_C2_START] = 1'b0;
                    set_irq   = 1'b1;
                    state_nxt = S_IDLE;
                end
            end
            S_RS_LOW: begin
                if (!scl_s_r) begin
                    sda_oen_nxt = 1'b1;
                    brg_val     = rel_half;
                    brg_load    = 1'b1;
                    state_nxt   = S_RS_SDAHI;
                end
            end
            S_RS_SDAHI: begin
                if (timeout) begin
                    if (sda_s_r) begin
                        scl_oen_nxt = 1'b1;
                        state_nxt   = S_RS_WAITHI;
                    end else begin
                        collide = 1'b1;
                    end
                end
            end
            S_RS_WAITHI: begin
                if (scl_s_r) begin
                    if (!sda_s_r) begin
                        collide = 1'b1;
                    end else begin
                        brg_load  = 1'b1;
                        state_nxt = S_RS_HIGH;
                    end
                end
            end
            S_RS_HIGH: begin
                if (!scl_s_r || !sda_s_r) begin
                    collide = 1'b1;
                end else if (timeout) begin
                    sda_oen_nxt = 1'b0;
                    brg_load    = 1'b1;
                    state_nxt   = S_RS_SDALO;
                end
            end
            S_RS_SDALO: begin
                if (timeout) begin
                    cmd_nxt[`IMSB_C2_RESTART] = 1'b0;
                    set_irq   = 1'b1;
                    state_nxt = S_IDLE;
                end
            end
            S_BIT_LOW: begin
                // data moves only once scl is already low
                sda_oen_nxt = rx_mode_r | (bit_cnt_r == `IMSB_ACK_BIT) | shift_r[7];
                if (timeout) begin
                    scl_oen_nxt = 1'b1;
                    state_nxt   = S_BIT_WAIT;
                end
            end
            S_BIT_WAIT: begin
                if (scl_s_r) begin
                    brg_load  = 1'b1;
                    state_nxt = S_BIT_HIGH;
                end
            end
            S_BIT_HIGH: begin
                if (timeout) begin
                    if (bit_cnt_r == `IMSB_ACK_BIT) begin
                        ackstat_nxt = sda_s_r;
                        set_irq     = 1'b1;
                        scl_oen_nxt = 1'b0;
                        state_nxt   = S_IDLE;
                    end else if (rx_mode_r && bit_cnt_r == `IMSB_LAST_DATA_BIT) begin
                        buf_nxt     = {shift_r[6:0], sda_s_r};
                        full_nxt    = 1'b1;
                        set_ovf     = full_r;
                        set_irq     = 1'b1;
                        cmd_nxt[`IMSB_C2_RECEIVE] = 1'b0;
                        scl_oen_nxt = 1'b0;
                        state_nxt   = S_IDLE;
                    end else if (!rx_mode_r && shift_r[7] && !sda_s_r) begin
                        collide = 1'b1;
                    end else begin
                        shift_nxt   = {shift_r[6:0], sda_s_r};
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                        if (!rx_mode_r && bit_cnt_r == `IMSB_LAST_DATA_BIT)
                            full_nxt = 1'b0;
                        scl_oen_nxt = 1'b0;
                        brg_load    = 1'b1;
                        state_nxt   = S_BIT_LOW;
                    end
                end
            end
            S_AK_LOW: begin
                if (timeout) begin
                    scl_oen_nxt = 1'b1;
                    state_nxt   = S_AK_WAIT;
                end
            end
            S_AK_WAIT: begin
                if (scl_s_r) begin
                    brg_load  = 1'b1;
                    state_nxt = S_AK_HIGH;
                end
            end
            S_AK_HIGH: begin
                if (timeout) begin
                    scl_oen_nxt = 1'b0;
                    cmd_nxt[`IMSB_C2_ACKSEQ] = 1'b0;
                    set_irq   = 1'b1;
                    state_nxt = S_IDLE;
                end
            end
            S_SP_WAITLO: begin
                if (!sda_s_r) begin
                    brg_load  = 1'b1;
                    state_nxt = S_SP_LOW;
                end
            end
            S_SP_LOW: begin
                if (timeout) begin
                    scl_oen_nxt = 1'b1;
                    state_nxt   = S_SP_WAITHI;
                end
            end
            S_SP_WAITHI: begin
                if (scl_s_r) begin
                    brg_load  = 1'b1;
                    state_nxt = S_SP_HIGH;
                end
            end
            S_SP_HIGH: begin
                if (timeout) begin
                    sda_oen_nxt = 1'b1;
                    state_nxt   = S_SP_WAITP;
                end
            end
            S_SP_WAITP: begin
                if (sda_s_r && scl_s_r) begin
                    brg_load  = 1'b1;
                    state_nxt = S_SP_END;
                end
            end
            S_SP_END: begin
                if (timeout) begin
                    cmd_nxt[`IMSB_C2_STOP] = 1'b0;
                    set_irq   = 1'b1;
                    state_nxt = S_IDLE;
                end
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
        if (collide) begin
            set_bcl     = 1'b1;
            sda_oen_nxt = 1'b1;
            scl_oen_nxt = 1'b1;
            cmd_nxt     = 5'h00;
            state_nxt   = S_IDLE;
        end
    end

    // registers and flags; a hardware set wins over a software clear
    always @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            state_r              <= S_IDLE;
            cmd_r                <= 5'h00;
            ackdt_r              <= 1'b0;
            ackstat_r            <= 1'b0;
            baud_r               <= `IMSB_RST_BAUD;
            buf_r                <= `IMSB_RST_BYTE;
            full_r               <= 1'b0;
            shift_r              <= `IMSB_RST_BYTE;
            bit_cnt_r            <= 4'h0;
            rx_mode_r            <= 1'b0;
            start_seen_r         <= 1'b0;
            stop_seen_r          <= 1'b0;
            write_collision_flag_r               <= 1'b0;
            ovf_r                <= 1'b0;
            O_RDATA              <= `IMSB_RST_BYTE;
            O_SDA                <= 1'b0;
            O_SCL                <= 1'b0;
            O_SDA_OE_N           <= 1'b1;
            O_SCL_OE_N           <= 1'b1;
            O_PORT_IRQ_FLAG      <= 1'b0;
            O_BUS_COLLISION_FLAG <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            cmd_r      <= cmd_nxt;
            ackstat_r  <= ackstat_nxt;
            buf_r      <= buf_nxt;
            full_r     <= full_nxt;
            shift_r    <= shift_nxt;
            bit_cnt_r  <= bit_cnt_nxt;
            rx_mode_r  <= rx_mode_nxt;
            O_SDA      <= 1'b0;
            O_SCL      <= 1'b0;
            O_SDA_OE_N <= sda_oen_nxt;
            O_SCL_OE_N <= scl_oen_nxt;
            if (wr_c2)
                ackdt_r <= I_WDATA[`IMSB_C2_ACKDATA];
            if (wr_baud)
                baud_r <= I_WDATA[6:0];
            // start/stop seen from the lines themselves
            if (scl_s_r && sda_d_r && !sda_s_r) begin
                start_seen_r <= 1'b1;
                stop_seen_r  <= 1'b0;
            end else if (scl_s_r && !sda_d_r && sda_s_r) begin
                start_seen_r <= 1'b0;
                stop_seen_r  <= 1'b1;
            end
            O_PORT_IRQ_FLAG <= set_irq |
                (O_PORT_IRQ_FLAG & ~(wr_flags & I_WDATA[`IMSB_FL_PORT_IRQ]));
            O_BUS_COLLISION_FLAG <= set_bcl |
                (O_BUS_COLLISION_FLAG & ~(wr_flags & I_WDATA[`IMSB_FL_BUS_COLL]));
            write_collision_flag_r <= set_write_collision_flag | (write_collision_flag_r & ~(wr_flags & I_WDATA[`IMSB_FL_WR_COLL]));
            ovf_r  <= set_ovf | (ovf_r & ~(wr_flags & I_WDATA[`IMSB_FL_RX_OVF]));
            // read data stands in the cycle after the strobe only
            if (I_RD) begin
                case (I_ADDR)
                    `IMSB_OFS_CTRL2:     O_RDATA <= {1'b0, ackstat_r, ackdt_r, cmd_r};
                    `IMSB_OFS_STATUS:    O_RDATA <= {3'h0, stop_seen_r, start_seen_r, 2'h0, full_r};
                    `IMSB_OFS_ADDR_BAUD: O_RDATA <= {1'b0, baud_r};
                    `IMSB_OFS_BUFFER:    O_RDATA <= buf_r;
                    `IMSB_OFS_FLAGS:     O_RDATA <= {4'h0, ovf_r, write_collision_flag_r, O_BUS_COLLISION_FLAG, O_PORT_IRQ_FLAG};
                    default:             O_RDATA <= `IMSB_RST_BYTE;
                endcase
            end else begin
                O_RDATA <= `IMSB_RST_BYTE;
            end
        end
    end

endmodule

`default_nettype wire

//--- testbench/imsb_core_chk.sv
// port assertions for the i2c master sequencer
// assumes binding to imsb_core with open-drain lines resolved outside
`default_nettype none
module imsb_core_chk (
    input wire logic       I_REF_CLK,
    input wire logic       I_RST_N,
    input wire logic [7:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic       I_WR,
    input wire logic       I_SCL,
    input wire logic       O_SDA,
    input wire logic       O_SDA_OE_N,
    input wire logic       O_SCL,
    input wire logic       O_SCL_OE_N,
    input wire logic       O_PORT_IRQ_FLAG,
    input wire logic       O_BUS_COLLISION_FLAG
);
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_N);
    logic clr_w;
    assign clr_w = I_WR && I_ADDR == 8'h10;
    a_sda_open_drain: assert property (O_SDA == 1'b0)
        else $error("sda data level not zero");
    a_scl_open_drain: assert property (O_SCL == 1'b0)
        else $error("scl data level not zero");
    a_reset_lines_free: assert property ($rose(I_RST_N) |-> O_SDA_OE_N && O_SCL_OE_N)
        else $error("lines pulled right after reset");
    a_irq_sticky: assert property (O_PORT_IRQ_FLAG && !(clr_w && I_WDATA[0]) |=> O_PORT_IRQ_FLAG)
        else $error("port irq flag lost");
    a_coll_sticky: assert property (O_BUS_COLLISION_FLAG && !(clr_w && I_WDATA[1]) |=> O_BUS_COLLISION_FLAG)
        else $error("collision flag lost");
    a_coll_release: assert property ($rose(O_BUS_COLLISION_FLAG) |-> ##[0:2] O_SDA_OE_N && O_SCL_OE_N)
        else $error("lines held after collision");
    a_start_scl_high: assert property ($fell(O_SDA_OE_N) && O_SCL_OE_N && $past(O_SCL_OE_N) |-> $past(I_SCL))
        else $error("sda pulled while scl low");
    a_scl_high_min: assert property ($rose(O_SCL_OE_N) |=> O_SCL_OE_N [*2])
        else $error("scl high time too short");
    c_start: cover property ($fell(O_SDA_OE_N) && O_SCL_OE_N);
    c_coll: cover property ($rose(O_BUS_COLLISION_FLAG));
    c_irq: cover property ($rose(O_PORT_IRQ_FLAG));
endmodule
bind imsb_core imsb_core_chk u_chk (.I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_SCL(I_SCL), .O_SDA(O_SDA), .O_SDA_OE_N(O_SDA_OE_N),
    .O_SCL(O_SCL), .O_SCL_OE_N(O_SCL_OE_N), .O_PORT_IRQ_FLAG(O_PORT_IRQ_FLAG),
    .O_BUS_COLLISION_FLAG(O_BUS_COLLISION_FLAG));
`default_nettype wire

//--- testbench/imsb_slave_model.sv
// behavioural slave on the resolved two-wire lines
// assumes the bench resolves both lines with pull-ups from all pull flags
`default_nettype none
module imsb_slave_model (
    input  wire logic i_sda,
    input  wire logic i_scl,
    input  wire logic i_nack,
    input  wire logic i_stretch,
    output var logic  o_sda_low,
    output var logic  o_scl_low
);
    timeunit 1ns;
    timeprecision 1ns;
    int falls = 0;
    initial begin
        o_sda_low = 1'b0;
        o_scl_low = 1'b0;
    end
    always @(negedge i_sda) if (i_scl) falls = 0;
    always @(negedge i_scl) begin
        falls = falls + 1;
        o_sda_low = falls % 9 == 0 && !i_nack;
        if (i_stretch) begin
            o_scl_low = 1'b1;
            #600;
            o_scl_low = 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- testbench/test_i2c_master_start_brg.sv
// self-checking bench for imsb_core with a behavioural slave
// assumes 20 MHz clock and pull-ups on both lines
`default_nettype none
module test_i2c_master_start_brg;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk, rst_n, wr_s, rd_s, tb_low, nack, stretch;
    logic [7:0] addr, wdata, d, b, got;
    logic [31:0] seed;
    wire logic [7:0] rdata;
    wire logic  sda, scl, sda_d, scl_d, sda_oe_n, scl_oe_n, irq, coll, s_sda, s_scl;
    int         num_errors = 0, compares = 0, cyc = 0, hi = 0, hmin = 9999, rl;
    logic       q[$];
    assign sda = !(!sda_oe_n || s_sda || tb_low);
    assign scl = !(!scl_oe_n || s_scl || tb_low);
    imsb_core DUT (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s),
        .I_RD(rd_s), .O_RDATA(rdata), .I_SDA(sda), .O_SDA(sda_d), .O_SDA_OE_N(sda_oe_n), .I_SCL(scl),
        .O_SCL(scl_d), .O_SCL_OE_N(scl_oe_n), .O_PORT_IRQ_FLAG(irq), .O_BUS_COLLISION_FLAG(coll));
    imsb_slave_model u_slv (.i_sda(sda), .i_scl(scl), .i_nack(nack), .i_stretch(stretch),
        .o_sda_low(s_sda), .o_scl_low(s_scl));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge scl) q.push_back(sda);
    always @(posedge clk) begin
        cyc++;
        if (scl) hi++;
        else begin
            if (hi > 0 && hi < hmin) hmin = hi;
            hi = 0;
        end
        if (cyc == 30000) begin
            num_errors++;
            report_and_stop();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic report_and_stop();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic wirq();
        for (int n = 0; n < 2000 && irq !== 1'b1; n++) @(posedge clk);
        chk({7'h0, irq}, 8'h01);
    endtask
    initial begin
        {rst_n, wr_s, rd_s, tb_low, nack, stretch} = 6'b0;
        {addr, wdata} = 16'h0000;
        seed = 32'hb859_e99e;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        foreach (b[i]) begin
            rd(8'(i * 4), d);
            chk(d, 8'h00);
        end
        wr(8'h08, 8'hff);
        rd(8'h08, d);
        chk(d & 8'h7f, 8'h7f);
        rl = 1;
        wr(8'h08, 8'(rl));
        wr(8'h00, 8'h01);
        wr(8'h0c, 8'h5a);
        wr(8'h00, 8'h04);
        wirq();
        rd(8'h10, d);
        chk(d & 8'h05, 8'h05);
        rd(8'h00, d);
        chk(d & 8'h07, 8'h00);
        rd(8'h04, d);
        chk(d & 8'h08, 8'h08);
        chk({7'h0, sda_oe_n}, 8'h00);
        for (int i = 0; i < 2; i++) begin
            nack = i[0];
            stretch = i[0];
            seed = lfsr(seed);
            b = i ? seed[7:0] | 8'h01 : seed[7:0] & 8'hfe;
            wr(8'h10, 8'hff);
            q.delete();
            wr(8'h0c, b);
            if (i) wr(8'h00, 8'h02);
            wirq();
            foreach (got[k]) got[k] = q[7 - k];
            chk(got, b);
            chk(8'(q.size()), 8'd9);
            rd(8'h00, d);
            chk(d & 8'h42, i ? 8'h40 : 8'h00);
        end
        chk({7'h0, hmin >= 2 * (rl + 1)}, 8'h01);
        stretch = 1'b0;
        wr(8'h10, 8'hff);
        wr(8'h00, 8'h02);
        wirq();
        rd(8'h00, d);
        chk(d & 8'h02, 8'h00);
        chk({4'h0, sda_d, scl_d, sda_oe_n, scl_oe_n}, 8'h01);
        wr(8'h10, 8'hff);
        wr(8'h0c, 8'ha1);
        wirq();
        wr(8'h10, 8'hff);
        wr(8'h00, 8'h28);
        wirq();
        rd(8'h0c, d);
        chk(d, 8'hff);
        wr(8'h10, 8'hff);
        wr(8'h00, 8'h30);
        wirq();
        rd(8'h00, d);
        chk(d & 8'h38, 8'h20);
        wr(8'h10, 8'hff);
        wr(8'h00, 8'h04);
        wirq();
        rd(8'h04, d);
        chk(d & 8'h10, 8'h10);
        rd(8'h00, d);
        chk({d[2], sda_oe_n, scl_oe_n}, 8'h03);
        @(posedge clk);
        tb_low <= 1'b1;
        wr(8'h10, 8'hff);
        wr(8'h00, 8'h01);
        repeat (40) @(posedge clk);
        rd(8'h00, d);
        chk({d[0], coll, sda_oe_n, scl_oe_n}, 8'h07);
        tb_low <= 1'b0;
        report_and_stop();
    end
endmodule
`default_nettype wire
